/* testbench/rtccr_host_model.sv */
// Two-wire bus host model that drives the clock/calendar client.
`timescale 1ns/100ps
module rtccr_host_model
(
	// Clock and resolved wire.
	input wire logic clk,
	input wire logic sda_line,
	// Driven bus pins; a high data drive means released.
	output logic scl,
	output logic sda_drv
);
	// Half bus period in system cycles; the client needs at least four.
	localparam int HALF = 8;

	// -----------------------------------------
	// Bus sequencing
	// -----------------------------------------
	// Both lines idle high until the first start.
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Start or repeated start: data falls only while the clock is high.
	task automatic start_cond();
		sda_drv = 1'b1;
		wait_clk(HALF);
		scl = 1'b1;
		wait_clk(HALF);
		sda_drv = 1'b0;
		wait_clk(HALF);
		scl = 1'b0;
		wait_clk(2);
	endtask

	task automatic stop_cond();
		sda_drv = 1'b0;
		wait_clk(HALF);
		scl = 1'b1;
		wait_clk(HALF);
		sda_drv = 1'b1;
		wait_clk(HALF);
	endtask

	// Data moves two cycles after the clock falls, so it never changes under a high clock.
	task automatic xfer_bit(input logic b, output logic got);
		sda_drv = b;
		wait_clk(HALF);
		scl = 1'b1;
		wait_clk(HALF - 2);
		got = sda_line;
		wait_clk(2);
		scl = 1'b0;
		wait_clk(2);
	endtask

	// Bytes go out most significant bit first; the ninth clock returns the client's answer.
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			xfer_bit(d[i], g);
		xfer_bit(1'b1, g);
		ack = ~g;
	endtask

	// The host acknowledges every byte but the last, which ends the read.
	task automatic read_byte(input logic last, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--)
		begin
			xfer_bit(1'b1, g);
			d[i] = g;
		end
		xfer_bit(last, g);
	endtask
endmodule

/* testbench/rtccr_top_tb_top.sv */
// Self-checking bench for the clock/calendar register map block.
`timescale 1ns/100ps
module rtccr_top_tb_top import rtccr_pkg::*;;
	localparam int FAIL = 64;
	localparam int LIMIT = 60000;
	localparam logic [7:0] WR = {RTCCR_CLIENT_CODE, 1'b0};
	localparam logic [7:0] RD = {RTCCR_CLIENT_CODE, 1'b1};
	logic ref_clk, reset, backup, x1, scl, sda_drv, sda_line;
	logic sda_out, sda_oe_n, xtal_en, tick, osc_run, ack;
	logic [7:0] rd;
	int n_fail = 0;
	int cmp_count = 0;
	int n_tick = 0;
	int cycles = 0;
	// Address, written value, value expected back; reserved slots 0x09, 0x10 and 0x17 are never written.
	logic [23:0] rows [14] = '{24'h01ff7f, 24'h03ff1f, 24'h04ff3f, 24'h0fff1f, 24'h08a5a5, 24'h16ff1f,
		24'h1fff00, 24'h1bffff, 24'h0d8080, 24'h140080, 24'h024040, 24'h0c0040, 24'h133f7f, 24'h205a5a};

	rtccr_top #(.OSC_FAIL_CYCLES(FAIL)) i_rtccr_top (.REF_CLK(ref_clk), .RESET(reset), .SCL(scl),
		.SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .X1_IN(x1), .BACKUP_MODE(backup),
		.XTAL_ENABLE(xtal_en), .TIMEBASE_TICK(tick), .OSC_RUNNING(osc_run));
	rtccr_host_model i_rtccr_host_model (.clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

	// Open-drain data wire with pull-up: low whenever either side pulls.
	assign sda_line = sda_drv & (sda_oe_n | sda_out);

	// -----------------------------------------
	// Clock, tick count and hang guard
	// -----------------------------------------
	// System clock at 125 MHz.
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// Counts timebase pulses and cuts the run short if it hangs.
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (tick === 1'b1)
			n_tick <= n_tick + 1;
		if (cycles == LIMIT)
		begin
			n_fail = n_fail + 1;
			wrap_up();
		end
	end

	// -----------------------------------------
	// Tasks
	// -----------------------------------------
	task automatic wrap_up();
		if (n_fail == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// The link clock starts off the system clock's phase and stops between bursts.
	task automatic x1_pulses(input int n);
		#3;
		repeat (n)
		begin
			#32 x1 = 1'b1;
			#32 x1 = 1'b0;
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		i_rtccr_host_model.start_cond();
		i_rtccr_host_model.write_byte(WR, ack);
		i_rtccr_host_model.write_byte(a, ack);
		i_rtccr_host_model.write_byte(d, ack);
		i_rtccr_host_model.stop_cond();
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		i_rtccr_host_model.start_cond();
		i_rtccr_host_model.write_byte(WR, ack);
		i_rtccr_host_model.write_byte(a, ack);
		i_rtccr_host_model.start_cond();
		i_rtccr_host_model.write_byte(RD, ack);
		i_rtccr_host_model.read_byte(1'b1, d);
		i_rtccr_host_model.stop_cond();
	endtask

	// -----------------------------------------
	// Main sequence
	// -----------------------------------------
	// Reset, the table of register round trips, then the awkward cases.
	initial
	begin
		reset = 1'b1;
		backup = 1'b0;
		x1 = 1'b0;
		idle(4);
		reset = 1'b0;
		idle(5);
		check({3'h0, sda_out, xtal_en, osc_run, sda_oe_n, tick}, 8'h02);
		reg_read(8'h00, rd);
		check(rd, 8'h00);
		foreach (rows[i])
		begin
			reg_write(rows[i][23:16], rows[i][15:8]);
			reg_read(rows[i][23:16], rd);
			check(rd, rows[i][7:0]);
		end
		// Out-of-range address and a foreign control code are both refused.
		i_rtccr_host_model.start_cond();
		i_rtccr_host_model.write_byte(WR, ack);
		i_rtccr_host_model.write_byte(8'h60, ack);
		i_rtccr_host_model.stop_cond();
		check({7'h0, ack}, 8'h00);
		i_rtccr_host_model.start_cond();
		i_rtccr_host_model.write_byte(8'hd0, ack);
		i_rtccr_host_model.stop_cond();
		check({7'h0, ack}, 8'h00);
		// Burst write across the top of user memory wraps to its bottom.
		i_rtccr_host_model.start_cond();
		i_rtccr_host_model.write_byte(WR, ack);
		i_rtccr_host_model.write_byte(8'h5e, ack);
		i_rtccr_host_model.write_byte(8'h11, ack);
		i_rtccr_host_model.write_byte(8'h22, ack);
		i_rtccr_host_model.write_byte(8'h33, ack);
		i_rtccr_host_model.stop_cond();
		reg_read(8'h5f, rd);
		check(rd, 8'h22);
		i_rtccr_host_model.start_cond();
		i_rtccr_host_model.write_byte(RD, ack);
		i_rtccr_host_model.read_byte(1'b1, rd);
		i_rtccr_host_model.stop_cond();
		check(rd, 8'h33);
		// Register read across 0x1F wraps to 0x00, not into user memory.
		reg_write(8'h00, 8'h45);
		reg_read(8'h1f, rd);
		i_rtccr_host_model.start_cond();
		i_rtccr_host_model.write_byte(RD, ack);
		i_rtccr_host_model.read_byte(1'b1, rd);
		i_rtccr_host_model.stop_cond();
		check(rd, 8'h45);
		// Backup supply: bus ignored, contents kept.
		backup = 1'b1;
		idle(4);
		i_rtccr_host_model.start_cond();
		i_rtccr_host_model.write_byte(WR, ack);
		i_rtccr_host_model.stop_cond();
		check({7'h0, ack}, 8'h00);
		backup = 1'b0;
		idle(4);
		reg_read(8'h08, rd);
		check(rd, 8'ha5);
		reg_read(8'h5e, rd);
		check(rd, 8'h11);
		// Crystal source: ticks per edge, running flag live in 0x03.
		reg_write(8'h00, 8'h80);
		check({7'h0, xtal_en}, 8'h01);
		n_tick = 0;
		fork
			x1_pulses(150);
			reg_read(8'h03, rd);
		join
		idle(8);
		check(n_tick[7:0], 8'h96);
		check(rd, 8'h3f);
		check({7'h0, osc_run}, 8'h01);
		idle(80);
		check({7'h0, osc_run}, 8'h00);
		// External clock source: flag only after the 32nd edge.
		reg_write(8'h00, 8'h00);
		reg_write(8'h07, 8'h08);
		check({7'h0, xtal_en}, 8'h00);
		n_tick = 0;
		x1_pulses(31);
		idle(2);
		check({7'h0, osc_run}, 8'h00);
		x1_pulses(9);
		idle(8);
		check({7'h0, osc_run}, 8'h01);
		check(n_tick[7:0], 8'h28);
		// Neither source enabled: edges are ignored.
		reg_write(8'h07, 8'h00);
		n_tick = 0;
		x1_pulses(40);
		idle(80);
		check(n_tick[7:0], 8'h00);
		check({7'h0, osc_run}, 8'h00);
		// Reset in mid-run clears the map and the outputs but leaves user memory alone.
		reset = 1'b1;
		idle(4);
		check({3'h0, sda_out, xtal_en, osc_run, sda_oe_n, tick}, 8'h02);
		reset = 1'b0;
		idle(5);
		reg_read(8'h08, rd);
		check(rd, 8'h00);
		reg_read(8'h5e, rd);
		check(rd, 8'h11);
		wrap_up();
	end
endmodule

/* verilog/rtccr_pkg.sv */
// Constants, types and helpers shared by the clock/calendar register map block.
// Behaviour
// - Registers and user memory share one space, reached by control code 1101111 plus direction.
// - A register address beyond the implemented range is not acknowledged and not accessed.
// - Clock/calendar, control, alarm and time-stamp registers decode at 0x00 to 0x1F.
// - Sixty-four bytes of user memory decode at 0x20 to 0x5F, separate from registers.
// - All registers and memory bytes keep their contents while on backup supply.
// - Alarm hours format bit is read-only and mirrors the timekeeping hours format bit.
// - Second alarm polarity bit is read-only and mirrors the first alarm polarity bit.
// - Unimplemented bit positions have no storage; writes to them do nothing.
// - Timebase comes from the crystal oscillator or from an external clock input.
// - The crystal oscillator runs only while the start bit in seconds is set.
// - Timekeeping advances from the 32.768 kHz reference, whatever its source; here each enabled edge only pulses TIMEBASE_TICK, no register advances.
// - The external clock is the timebase only while the external select bit is set.
// - Running flag sets after 32 timebase cycles, clears after the failure timeout.
// - Control byte bit zero selects direction: one reads, zero writes.
// - Timekeeping buffer refreshes when a register read starts and when 0x1F wraps.
package rtccr_pkg;

	// ----------------------------------------
	// Addressing.
	// ----------------------------------------
	localparam logic [6:0] RTCCR_CLIENT_CODE = 7'h6f;
	localparam logic [7:0] RTCCR_RTCC_FIRST = 8'h00;
	localparam logic [7:0] RTCCR_RTCC_LAST = 8'h1f;
	localparam logic [7:0] RTCCR_SRAM_FIRST = 8'h20;
	localparam logic [7:0] RTCCR_SRAM_LAST = 8'h5f;
	localparam int RTCCR_RTCC_REGS = 32;
	localparam int RTCCR_SRAM_BYTES = 64;
	localparam int RTCCR_SHADOW_REGS = 7;

	// ----------------------------------------
	// Register offsets and bit positions.
	// ----------------------------------------
	localparam logic [4:0] RTCCR_SECONDS_COUNT = 5'h00;
	localparam logic [4:0] RTCCR_HOURS_COUNT = 5'h02;
	localparam logic [4:0] RTCCR_WEEKDAY_POWER = 5'h03;
	localparam logic [4:0] RTCCR_OUTPUT_ALARM_CTRL = 5'h07;
	localparam logic [4:0] RTCCR_ALARM0_HOURS = 5'h0c;
	localparam logic [4:0] RTCCR_ALARM0_WEEKDAY = 5'h0d;
	localparam logic [4:0] RTCCR_ALARM1_HOURS = 5'h13;
	localparam logic [4:0] RTCCR_ALARM1_WEEKDAY = 5'h14;
	localparam int RTCCR_OSC_START_BIT = 7;
	localparam int RTCCR_HOUR_FORMAT_BIT = 6;
	localparam int RTCCR_OSC_RUNNING_BIT = 5;
	localparam int RTCCR_EXT_CLOCK_BIT = 3;
	localparam int RTCCR_ALARM_POL_BIT = 7;
	localparam logic [7:0] RTCCR_REG_RESET = 8'h00;

	// ----------------------------------------
	// Timing.
	// ----------------------------------------
	localparam int RTCCR_REF_CLK_HZ = 125000000;
	localparam int RTCCR_TIMEBASE_HZ = 32768;
	localparam logic [5:0] RTCCR_OSC_RUN_EDGES = 6'h20;
	localparam int RTCCR_OSC_FAIL_US = 1000;
	localparam int RTCCR_OSC_FAIL_CYCLES = RTCCR_OSC_FAIL_US * (RTCCR_REF_CLK_HZ / 1000000);

	// ----------------------------------------
	// Types.
	// ----------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_CTRL, ST_ADDR, ST_WRITE, ST_READ} rtccr_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic x1;
		logic backup;
	} rtccr_pins_t;

	// Storage mask per register; bits outside it are not kept and read as zero, except the running flag and the mirrored format and polarity bits.
	function automatic logic [7:0] rtccr_wmask(input logic [4:0] a);
		logic [7:0] m;
		m = 8'h00;
		case (a)
			5'h00, 5'h06, 5'h07, 5'h08, 5'h0d, 5'h1b: m = 8'hff;
			5'h01, 5'h02, 5'h0a, 5'h0b, 5'h11, 5'h12, 5'h14, 5'h18, 5'h19, 5'h1c, 5'h1d: m = 8'h7f;
			5'h04, 5'h05, 5'h0c, 5'h0e, 5'h13, 5'h15, 5'h1a, 5'h1e: m = 8'h3f;
			5'h03, 5'h0f, 5'h16: m = 8'h1f;
			default: m = 8'h00;
		endcase
		return m;
	endfunction

endpackage

/* verilog/rtccr_top.sv */
// Two-wire client, register map, user memory and timebase supervision of the clock/calendar.
`timescale 1ns/100ps
module rtccr_top
	import rtccr_pkg::*;
#(
	parameter int OSC_FAIL_CYCLES = RTCCR_OSC_FAIL_CYCLES
)
(
	// Clock and reset.
	input wire logic REF_CLK,
	input wire logic RESET,
	// Two-wire host bus pins.
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N,
	// Timebase pin and supply state.
	input wire logic X1_IN,
	input wire logic BACKUP_MODE,
	// Oscillator control and status.
	output logic XTAL_ENABLE,
	output logic TIMEBASE_TICK,
	output logic OSC_RUNNING
);

	localparam int GAP_W = $clog2(OSC_FAIL_CYCLES + 1);

	rtccr_pins_t pins_raw;
	rtccr_pins_t sync1_q;
	rtccr_pins_t sync2_q;
	rtccr_pins_t prev_q;
	rtccr_state_t state_q;
	logic [3:0] bit_cnt_q;
	logic in_ack_q;
	logic nack_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic sda_oe_n_q;
	logic sda_out_q;
	logic [7:0] regs_q [RTCCR_RTCC_REGS];
	logic [7:0] sram_q [RTCCR_SRAM_BYTES];
	logic [7:0] shadow_q [RTCCR_SHADOW_REGS];
	logic [5:0] edge_cnt_q;
	logic [GAP_W-1:0] gap_q;
	logic run_q;
	logic xtal_en_q;
	logic tick_q;
	logic [7:0] rd_raw;
	logic [7:0] rd_data;

	// ----------------------------------------
	// Pin synchronisers.
	// ----------------------------------------

	// Every pin passes two flops; edge detection compares the second stage with its delayed copy.
	assign pins_raw = '{scl: SCL, sda: SDA_IN, x1: X1_IN, backup: BACKUP_MODE};

	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			sync1_q <= '1;
			sync2_q <= '1;
			prev_q <= '1;
		end
		else
		begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// ----------------------------------------
	// Bus event and address decode.
	// ----------------------------------------

	// Start and stop are data edges while the clock line stays high.
	wire backup = sync2_q.backup;
	wire scl_rise = !prev_q.scl && sync2_q.scl;
	wire scl_fall = prev_q.scl && !sync2_q.scl;
	wire scl_high = prev_q.scl && sync2_q.scl;
	wire start_cond = scl_high && prev_q.sda && !sync2_q.sda;
	wire stop_cond = scl_high && !prev_q.sda && sync2_q.sda;
	wire byte_done = scl_fall && !in_ack_q && (bit_cnt_q == 4'h8) && (state_q != ST_IDLE);
	wire ack_end = scl_fall && in_ack_q;
	wire ctrl_match = (shift_q[7:1] == RTCCR_CLIENT_CODE);
	wire addr_ok = (shift_q <= RTCCR_SRAM_LAST);
	wire is_rtcc_ptr = (ptr_q <= RTCCR_RTCC_LAST);
	wire is_sram_ptr = (ptr_q >= RTCCR_SRAM_FIRST) && (ptr_q <= RTCCR_SRAM_LAST);
	wire [7:0] sram_off = ptr_q - RTCCR_SRAM_FIRST;
	wire [5:0] sram_idx = sram_off[5:0];
	wire [4:0] reg_idx = ptr_q[4:0];
	wire [7:0] wmask = rtccr_wmask(reg_idx);
	wire wr_en = byte_done && (state_q == ST_WRITE) && !backup;
	wire rtcc_wrap = (ptr_q == RTCCR_RTCC_LAST);
	wire [7:0] ptr_next = rtcc_wrap ? RTCCR_RTCC_FIRST : (ptr_q == RTCCR_SRAM_LAST) ? RTCCR_SRAM_FIRST : ptr_q + 8'h01;
	wire read_start = byte_done && (state_q == ST_CTRL) && ctrl_match && shift_q[0];
	wire shadow_load = (read_start && is_rtcc_ptr) || (byte_done && (state_q == ST_READ) && rtcc_wrap);
	wire ack_this = ((state_q == ST_CTRL) && ctrl_match) || ((state_q == ST_ADDR) && addr_ok) || (state_q == ST_WRITE);
	wire [2:0] tx_pos = 3'(4'h7 - bit_cnt_q);
	wire tx_bit = tx_q[tx_pos];
	wire drive_bit = scl_fall && !in_ack_q && (state_q == ST_READ) && (bit_cnt_q != 4'h0) && (bit_cnt_q < 4'h8);

	// ----------------------------------------
	// Read view of the map.
	// ----------------------------------------

	// Timekeeping bytes come from the buffer so a multi-byte read sees one consistent time.
	always_comb
	begin
		rd_raw = regs_q[reg_idx];
		if (reg_idx < 5'(RTCCR_SHADOW_REGS))
			rd_raw = shadow_q[reg_idx[2:0]];
		case (reg_idx)
			RTCCR_WEEKDAY_POWER: rd_raw[RTCCR_OSC_RUNNING_BIT] = run_q;
			RTCCR_ALARM0_HOURS, RTCCR_ALARM1_HOURS:
				rd_raw[RTCCR_HOUR_FORMAT_BIT] = regs_q[RTCCR_HOURS_COUNT][RTCCR_HOUR_FORMAT_BIT];
			RTCCR_ALARM1_WEEKDAY:
				rd_raw[RTCCR_ALARM_POL_BIT] = regs_q[RTCCR_ALARM0_WEEKDAY][RTCCR_ALARM_POL_BIT];
			default: rd_raw = rd_raw;
		endcase
		if (is_sram_ptr)
			rd_data = sram_q[sram_idx];
		else if (is_rtcc_ptr)
			rd_data = rd_raw;
		else
			rd_data = 8'h00;
	end

	// ----------------------------------------
	// Client state machine.
	// ----------------------------------------

	// The interface is dead on backup supply; a stop or a new start always resynchronises it.
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			in_ack_q <= 1'b0;
			nack_q <= 1'b0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
		end
		else if (backup || stop_cond)
		begin
			state_q <= ST_IDLE;
			in_ack_q <= 1'b0;
		end
		else if (start_cond)
		begin
			state_q <= ST_CTRL;
			bit_cnt_q <= 4'h0;
			in_ack_q <= 1'b0;
			nack_q <= 1'b0;
		end
		else
		begin
			if (scl_rise && (state_q != ST_IDLE))
			begin
				if (!in_ack_q && (bit_cnt_q < 4'h8))
				begin
					shift_q <= {shift_q[6:0], sync2_q.sda};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end
				else if (in_ack_q && (state_q == ST_READ))
					nack_q <= sync2_q.sda;
			end
			if (byte_done)
			begin
				in_ack_q <= 1'b1;
				case (state_q)
					ST_CTRL: if (!ctrl_match) state_q <= ST_IDLE;
					ST_ADDR:
					begin
						if (addr_ok)
							ptr_q <= shift_q;
						else
							state_q <= ST_IDLE;
					end
					ST_WRITE: ptr_q <= ptr_next;
					ST_READ: ptr_q <= ptr_next;
					default: state_q <= ST_IDLE;
				endcase
			end
			if (ack_end)
			begin
				in_ack_q <= 1'b0;
				bit_cnt_q <= 4'h0;
				case (state_q)
					ST_CTRL:
					begin
						state_q <= shift_q[0] ? ST_READ : ST_ADDR;
						tx_q <= rd_data;
					end
					ST_ADDR: state_q <= ST_WRITE;
					ST_READ:
					begin
						if (nack_q)
							state_q <= ST_IDLE;
						else
							tx_q <= rd_data;
					end
					default: state_q <= state_q;
				endcase
			end
		end
	end

	// Data line: acknowledge after received bytes, read data shifted out on falling clock edges.
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			sda_oe_n_q <= 1'b1;
			sda_out_q <= 1'b0;
		end
		else
		begin
			sda_out_q <= 1'b0;
			if (backup || stop_cond || start_cond)
				sda_oe_n_q <= 1'b1;
			else if (byte_done)
				sda_oe_n_q <= !ack_this;
			else if (ack_end)
				sda_oe_n_q <= ((state_q == ST_CTRL) && shift_q[0]) || ((state_q == ST_READ) && !nack_q) ? rd_data[7] : 1'b1;
			else if (drive_bit)
				sda_oe_n_q <= tx_bit;
		end
	end

	// ----------------------------------------
	// Register file and user memory.
	// ----------------------------------------

	// Only power-on reset clears the map; backup supply leaves every byte as it is.
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			for (int i = 0; i < RTCCR_RTCC_REGS; i++)
				regs_q[i] <= RTCCR_REG_RESET;
		end
		else if (wr_en && is_rtcc_ptr)
			regs_q[reg_idx] <= shift_q & wmask;
	end

	// User memory has no reset on purpose: it must survive everything except loss of all supply.
	always_ff @(posedge REF_CLK)
	begin
		if (wr_en && is_sram_ptr)
			sram_q[sram_idx] <= shift_q;
	end

	// Buffered timekeeping copy.
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			for (int i = 0; i < RTCCR_SHADOW_REGS; i++)
				shadow_q[i] <= RTCCR_REG_RESET;
		end
		else if (shadow_load)
		begin
			for (int i = 0; i < RTCCR_SHADOW_REGS; i++)
				shadow_q[i] <= regs_q[i];
		end
	end

	// ----------------------------------------
	// Timebase source and supervision.
	// ----------------------------------------

	// Crystal needs the start bit; the external clock is only taken with its select bit set.
	wire st_bit = regs_q[RTCCR_SECONDS_COUNT][RTCCR_OSC_START_BIT];
	wire ext_sel = regs_q[RTCCR_OUTPUT_ALARM_CTRL][RTCCR_EXT_CLOCK_BIT];
	wire src_en = ext_sel || st_bit;
	wire x1_rise = !prev_q.x1 && sync2_q.x1;
	wire tick = x1_rise && src_en;
	wire [5:0] edge_next = edge_cnt_q + 6'h01;
	wire gap_over = (gap_q == GAP_W'(OSC_FAIL_CYCLES));

	// The gap counter only needs to reach the timeout, so it saturates there.
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			edge_cnt_q <= 6'h00;
			gap_q <= '0;
			run_q <= 1'b0;
		end
		else if (tick)
		begin
			gap_q <= '0;
			if (edge_cnt_q < RTCCR_OSC_RUN_EDGES)
				edge_cnt_q <= edge_next;
			if (edge_next == RTCCR_OSC_RUN_EDGES)
				run_q <= 1'b1;
		end
		else if (gap_over)
		begin
			run_q <= 1'b0;
			edge_cnt_q <= 6'h00;
		end
		else
			gap_q <= gap_q + GAP_W'(1);
	end

	// Registered oscillator outputs.
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			xtal_en_q <= 1'b0;
			tick_q <= 1'b0;
		end
		else
		begin
			xtal_en_q <= st_bit && !ext_sel;
			tick_q <= tick;
		end
	end

	// Output ports.
	assign SDA_OUT = sda_out_q;
	assign SDA_OE_N = sda_oe_n_q;
	assign XTAL_ENABLE = xtal_en_q;
	assign TIMEBASE_TICK = tick_q;
	assign OSC_RUNNING = run_q;

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RESET);
	sequence s_read_start;
		read_start && is_rtcc_ptr;
	endsequence
	sequence s_read_wrap;
		byte_done && (state_q == ST_READ) && rtcc_wrap;
	endsequence
	AST_CLIENT_ACK:
	assert property (byte_done && (state_q == ST_CTRL) && ctrl_match |=> !SDA_OE_N)
	else $error("Matching control byte was not acknowledged.");
	AST_CLIENT_NACK:
	assert property (byte_done && (state_q == ST_CTRL) && !ctrl_match |=> SDA_OE_N && (state_q == ST_IDLE))
	else $error("Foreign control byte was acknowledged.");
	AST_RANGE_NACK:
	assert property (byte_done && (state_q == ST_ADDR) && !addr_ok |=> SDA_OE_N && (state_q == ST_IDLE))
	else $error("Out of range address was acknowledged.");
	AST_RTCC_WRITE:
	assert property (wr_en && is_rtcc_ptr |=> regs_q[$past(reg_idx)] == ($past(shift_q) & $past(wmask)))
	else $error("Register write did not land.");
	AST_SRAM_WRITE:
	assert property (wr_en && is_sram_ptr |=> sram_q[$past(sram_idx)] == $past(shift_q))
	else $error("User memory write did not land.");
	AST_BACKUP_IDLE:
	assert property (backup |=> (state_q == ST_IDLE) && SDA_OE_N && !wr_en)
	else $error("Bus active on backup supply.");
	AST_HOUR_MIRROR:
	assert property (((reg_idx == RTCCR_ALARM0_HOURS) || (reg_idx == RTCCR_ALARM1_HOURS)) && is_rtcc_ptr
		|-> rd_data[RTCCR_HOUR_FORMAT_BIT] == regs_q[RTCCR_HOURS_COUNT][RTCCR_HOUR_FORMAT_BIT])
	else $error("Alarm hour format does not mirror timekeeping.");
	AST_POL_MIRROR:
	assert property ((reg_idx == RTCCR_ALARM1_WEEKDAY) && is_rtcc_ptr
		|-> rd_data[RTCCR_ALARM_POL_BIT] == regs_q[RTCCR_ALARM0_WEEKDAY][RTCCR_ALARM_POL_BIT])
	else $error("Second alarm polarity does not mirror the first.");
	AST_UNIMPL:
	assert property ((regs_q[5'h09] == 8'h00) && (regs_q[5'h1f] == 8'h00) && !regs_q[RTCCR_WEEKDAY_POWER][7])
	else $error("Unimplemented bit holds a value.");
	AST_TICK_SOURCE:
	assert property (TIMEBASE_TICK |-> $past(src_en) && $past(x1_rise))
	else $error("Timebase tick without an enabled source.");
	AST_XTAL_START:
	assert property ($rose(st_bit) && !ext_sel |=> XTAL_ENABLE)
	else $error("Crystal not enabled after start bit.");
	AST_RUN_SET:
	assert property ($rose(run_q) |-> $past(tick) && ($past(edge_cnt_q) == 6'h1f))
	else $error("Running flag set before 32 cycles.");
	AST_RUN_CLEAR:
	assert property ($fell(run_q) |-> $past(gap_over))
	else $error("Running flag cleared before the timeout.");
	AST_DIRECTION:
	assert property (ack_end && (state_q == ST_CTRL) |=> (state_q == ($past(shift_q[0]) ? ST_READ : ST_ADDR)))
	else $error("Direction bit ignored.");
	AST_SHADOW_START:
	assert property (s_read_start |=> shadow_q[0] == $past(regs_q[0]))
	else $error("Buffer not refreshed at read start.");
	AST_SHADOW_WRAP:
	assert property (s_read_wrap |=> (shadow_q[2] == $past(regs_q[2])) && (ptr_q == RTCCR_RTCC_FIRST))
	else $error("Buffer not refreshed on wrap.");
endmodule
